// ### verilog/cpt_pkg.sv
// Purpose: Shared constants and types for the compare, PWM and phase counting timer.
// Assumes: Registers are 16 bits wide and addressed by a 4-bit word index.
// Notes: Field layouts are packed structs so both design files decode them alike.
package cpt_pkg;

  localparam int CPT_AW = 4;
  localparam int CPT_DW = 16;
  localparam int CPT_PRE_W = 5;

  // Register word indices.
  localparam logic [CPT_AW-1:0] OFS_MODE = 4'h0;
  localparam logic [CPT_AW-1:0] OFS_CTRL = 4'h1;
  localparam logic [CPT_AW-1:0] OFS_IO = 4'h2;
  localparam logic [CPT_AW-1:0] OFS_PHASE = 4'h3;
  localparam logic [CPT_AW-1:0] OFS_STAT = 4'h4;
  localparam logic [CPT_AW-1:0] OFS_CNT = 4'h5;
  localparam logic [CPT_AW-1:0] OFS_CMPA = 4'h6;
  localparam logic [CPT_AW-1:0] OFS_CMPB = 4'h7;
  localparam logic [CPT_AW-1:0] OFS_BUFA = 4'h8;
  localparam logic [CPT_AW-1:0] OFS_BUFB = 4'h9;

  // Count source codes.
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT_A = 3'h5;
  localparam logic [2:0] SRC_EXT_B = 3'h7;

  // Counter clear sources.
  localparam logic [1:0] CLR_FREE = 2'h0;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;

  // Output level at compare match.
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_TOG = 2'h2;

  // Active edge codes, shared by clock pins and capture inputs.
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  localparam int IO_B_LSB = 8;
  localparam int PIN_W = 7;
  localparam logic [CPT_DW-1:0] CNT_MAX = 16'hffff;
  localparam logic [CPT_DW-1:0] CNT_RST = 16'h0000;
  localparam logic [CPT_DW-1:0] CMP_RST = 16'hffff;
  localparam logic [CPT_DW-1:0] RD_ZERO = 16'h0000;

  typedef struct packed {
    logic phase;
    logic pwm;
    logic run;
  } cpt_mode_s;

  typedef struct packed {
    logic [1:0] clr;
    logic [1:0] edge_sel;
    logic [2:0] src;
  } cpt_ctrl_s;

  typedef struct packed {
    logic buf_en;
    logic [1:0] cap_edge;
    logic cap_en;
    logic out_en;
    logic [1:0] level;
  } cpt_pin_s;

  typedef struct packed {
    logic udf;
    logic ovf;
    logic flag_b;
    logic flag_a;
  } cpt_evt_s;

  localparam cpt_mode_s MODE_RST = 3'h0;
  localparam cpt_ctrl_s CTRL_RST = 7'h00;
  localparam cpt_pin_s PIN_RST = 7'h00;
  localparam cpt_evt_s EVT_NONE = 4'h0;
  localparam logic [7:0] PHASE_RST = 8'h00;

endpackage

// ### verilog/cpt_tick_src.sv
// Purpose: Count source for the timer: prescaler, clock pins and phase decoder.
// Assumes: Clock pins are asynchronous to mclk_in and are slow next to it.
// Notes: Produces one-cycle up and down pulses; run gating is left to the caller.
`timescale 1ns/1ps
module cpt_tick_src
  import cpt_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Configuration.
  input wire cpt_ctrl_s ctrl_in,
  input wire logic phase_in,
  input wire logic [7:0] cnten_in,
  // Pins.
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  // Count pulses.
  output logic up_out,
  output logic dn_out
);

  logic [CPT_PRE_W-1:0] pre;
  logic [CPT_PRE_W-1:0] next_pre;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] dly;
  logic div_tick;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic [7:0] cond;

  function automatic logic edge_hit(input logic now, input logic old, input logic [1:0] sel);
    logic r;
    logic f;
    r = now & ~old;
    f = ~now & old;
    case (sel)
      EDGE_RISE: edge_hit = r;
      EDGE_FALL: edge_hit = f;
      default: edge_hit = r | f;
    endcase
  endfunction

  always_comb begin
    next_pre = pre + 1'b1;
    a_rise = sync2[0] & ~dly[0];
    a_fall = ~sync2[0] & dly[0];
    b_rise = sync2[1] & ~dly[1];
    b_fall = ~sync2[1] & dly[1];
    case (ctrl_in.src)
      SRC_DIV1: div_tick = 1'b1;
      SRC_DIV2: div_tick = &pre[0:0];
      SRC_DIV4: div_tick = &pre[1:0];
      SRC_DIV8: div_tick = &pre[2:0];
      SRC_DIV32: div_tick = &pre[4:0];
      SRC_EXT_A: div_tick = edge_hit(sync2[0], dly[0], ctrl_in.edge_sel);
      SRC_EXT_B: div_tick = edge_hit(sync2[1], dly[1], ctrl_in.edge_sel);
      default: div_tick = 1'b0;
    endcase
    // Conditions 0 to 3 are A-leads-B steps, 4 to 7 are B-leads-A steps.
    cond = {b_fall & sync2[0], b_rise & ~sync2[0], a_fall & ~sync2[1], a_rise & sync2[1],
            b_fall & ~sync2[0], b_rise & sync2[0], a_fall & sync2[1], a_rise & ~sync2[1]};
    if (phase_in) begin
      up_out = |(cond[3:0] & cnten_in[3:0]);
      dn_out = |(cond[7:4] & cnten_in[7:4]);
    end else begin
      up_out = div_tick;
      dn_out = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre <= '0;
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      dly <= 2'h0;
    end else begin
      pre <= next_pre;
      sync1 <= {pin_b_in, pin_a_in};
      sync2 <= sync1;
      dly <= sync2;
    end
  end

endmodule

// ### verilog/cpt_timer.sv
// Purpose: 16-bit compare, PWM and two-phase counting timer with register port.
// Assumes: Single clock; pins are synchronised inside; software sees a plain port.
// Notes: Reads answer one cycle after the read strobe; writes take effect at once.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module cpt_timer
  import cpt_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Register port.
  input wire logic [CPT_AW-1:0] reg_addr_in,
  input wire logic [CPT_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [CPT_DW-1:0] reg_rdata_out,
  // External clock and phase pins.
  input wire logic clk_pin_a_in,
  input wire logic clk_pin_b_in,
  // Waveform pins, two-way.
  input wire logic wave_a_in,
  output logic wave_a_out,
  output logic wave_a_oe_out,
  input wire logic wave_b_in,
  output logic wave_b_out,
  output logic wave_b_oe_out,
  // Interrupt request pulses.
  output cpt_evt_s irq_out
);

  cpt_mode_s mode;
  cpt_mode_s next_mode;
  cpt_ctrl_s ctrl;
  cpt_ctrl_s next_ctrl;
  cpt_pin_s pin_a;
  cpt_pin_s next_pin_a;
  cpt_pin_s pin_b;
  cpt_pin_s next_pin_b;
  logic [7:0] cnten;
  logic [7:0] next_cnten;
  cpt_evt_s stat;
  cpt_evt_s next_stat;
  cpt_evt_s evt;
  logic dir;
  logic next_dir;
  logic [CPT_DW-1:0] cnt;
  logic [CPT_DW-1:0] next_cnt;
  logic [CPT_DW-1:0] cmp_a;
  logic [CPT_DW-1:0] next_cmp_a;
  logic [CPT_DW-1:0] cmp_b;
  logic [CPT_DW-1:0] next_cmp_b;
  logic [CPT_DW-1:0] buf_a;
  logic [CPT_DW-1:0] next_buf_a;
  logic [CPT_DW-1:0] buf_b;
  logic [CPT_DW-1:0] next_buf_b;
  logic [CPT_DW-1:0] next_rdata;
  logic next_wave_a;
  logic next_wave_b;
  cpt_evt_s next_irq;
  logic [1:0] wsync1;
  logic [1:0] wsync2;
  logic [1:0] wdly;
  logic src_up;
  logic src_dn;
  logic up;
  logic dn;
  logic step;
  logic hit_a;
  logic hit_b;
  logic cap_a;
  logic cap_b;
  logic clr_hit;
  logic pwm_only;

  function automatic logic wr_at(input logic [CPT_AW-1:0] ofs);
    wr_at = reg_wr_in && (reg_addr_in == ofs);
  endfunction

  function automatic logic cap_hit(input logic now, input logic old, input logic [1:0] sel);
    case (sel)
      EDGE_RISE: cap_hit = now & ~old;
      EDGE_FALL: cap_hit = ~now & old;
      default: cap_hit = now ^ old;
    endcase
  endfunction

  function automatic logic out_level(input logic cur, input logic [1:0] lvl);
    case (lvl)
      LVL_LOW: out_level = 1'b0;
      LVL_HIGH: out_level = 1'b1;
      LVL_TOG: out_level = ~cur;
      default: out_level = cur;
    endcase
  endfunction

  cpt_tick_src u_src (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .ctrl_in(ctrl),
    .phase_in(mode.phase),
    .cnten_in(cnten),
    .pin_a_in(clk_pin_a_in),
    .pin_b_in(clk_pin_b_in),
    .up_out(src_up),
    .dn_out(src_dn)
  );

  // Configuration and register writes.
  always_comb begin
    next_mode = mode;
    next_ctrl = ctrl;
    next_pin_a = pin_a;
    next_pin_b = pin_b;
    next_cnten = cnten;
    next_buf_a = buf_a;
    next_buf_b = buf_b;
    if (wr_at(OFS_MODE)) begin
      next_mode = reg_wdata_in[$bits(cpt_mode_s)-1:0];
    end
    if (wr_at(OFS_CTRL)) begin
      next_ctrl = reg_wdata_in[$bits(cpt_ctrl_s)-1:0];
    end
    if (wr_at(OFS_IO)) begin
      next_pin_a = reg_wdata_in[PIN_W-1:0];
      next_pin_b = reg_wdata_in[IO_B_LSB+PIN_W-1:IO_B_LSB];
    end
    if (wr_at(OFS_PHASE)) begin
      next_cnten = reg_wdata_in[7:0];
    end
    if (wr_at(OFS_BUFA)) begin
      next_buf_a = reg_wdata_in;
    end
    if (wr_at(OFS_BUFB)) begin
      next_buf_b = reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode <= MODE_RST;
      ctrl <= CTRL_RST;
      pin_a <= PIN_RST;
      pin_b <= PIN_RST;
      cnten <= PHASE_RST;
      buf_a <= CMP_RST;
      buf_b <= CMP_RST;
    end else begin
      mode <= next_mode;
      ctrl <= next_ctrl;
      pin_a <= next_pin_a;
      pin_b <= next_pin_b;
      cnten <= next_cnten;
      buf_a <= next_buf_a;
      buf_b <= next_buf_b;
    end
  end

  // Counter, compare, capture and waveform logic.
  always_comb begin
    pwm_only = mode.pwm & ~mode.phase;
    up = src_up & mode.run;
    // Down counts only come from the phase decoder, so other modes only increment.
    dn = src_dn & mode.run & mode.phase;
    step = up ^ dn;
    hit_a = step && (cnt == cmp_a) && !pin_a.cap_en;
    hit_b = step && (cnt == cmp_b) && !pin_b.cap_en;
    cap_a = pin_a.cap_en && cap_hit(wsync2[0], wdly[0], pin_a.cap_edge);
    cap_b = pin_b.cap_en && cap_hit(wsync2[1], wdly[1], pin_b.cap_edge);
    clr_hit = ((ctrl.clr == CLR_A) && hit_a) || ((ctrl.clr == CLR_B) && hit_b);
    evt = EVT_NONE;
    next_cnt = cnt;
    next_dir = dir;
    if (wr_at(OFS_CNT)) begin
      next_cnt = reg_wdata_in;
    end else if (clr_hit) begin
      next_cnt = CNT_RST;
    end else if (step && up) begin
      next_cnt = cnt + 1'b1;
      next_dir = 1'b1;
      evt.ovf = (cnt == CNT_MAX);
    end else if (step && dn) begin
      next_cnt = cnt - 1'b1;
      next_dir = 1'b0;
      evt.udf = (cnt == CNT_RST);
    end
    evt.flag_a = hit_a | cap_a;
    evt.flag_b = hit_b | cap_b;
    // Hardware loads win over a software write in the same cycle.
    next_cmp_a = cmp_a;
    next_cmp_b = cmp_b;
    if (wr_at(OFS_CMPA)) begin
      next_cmp_a = reg_wdata_in;
    end
    if (wr_at(OFS_CMPB)) begin
      next_cmp_b = reg_wdata_in;
    end
    if (cap_a) begin
      next_cmp_a = cnt;
    end else if (hit_a && pin_a.buf_en) begin
      next_cmp_a = buf_a;
    end
    if (cap_b) begin
      next_cmp_b = cnt;
    end else if (hit_b && pin_b.buf_en) begin
      next_cmp_b = buf_b;
    end
    // A flag set by an event in the clearing cycle survives the clear.
    next_stat = stat;
    if (wr_at(OFS_STAT)) begin
      next_stat = stat & ~reg_wdata_in[$bits(cpt_evt_s)-1:0];
    end
    next_stat = next_stat | evt;
    next_irq = evt;
    next_wave_a = wave_a_out;
    if (mode.pwm) begin
      // A equal to B gives a 0% duty: the low edge wins.
      if (hit_b) begin
        next_wave_a = 1'b0;
      end else if (hit_a) begin
        next_wave_a = 1'b1;
      end
    end else if (pin_a.out_en && hit_a) begin
      next_wave_a = out_level(wave_a_out, pin_a.level);
    end
    next_wave_b = wave_b_out;
    if (!pwm_only && pin_b.out_en && hit_b) begin
      next_wave_b = out_level(wave_b_out, pin_b.level);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= CNT_RST;
      dir <= 1'b0;
      cmp_a <= CMP_RST;
      cmp_b <= CMP_RST;
      stat <= EVT_NONE;
      irq_out <= EVT_NONE;
      wave_a_out <= 1'b0;
      wave_b_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      dir <= next_dir;
      cmp_a <= next_cmp_a;
      cmp_b <= next_cmp_b;
      stat <= next_stat;
      irq_out <= next_irq;
      wave_a_out <= next_wave_a;
      wave_b_out <= next_wave_b;
    end
  end

  // Pin drive enables; an undriven pin is left to the port logic.
  always_comb begin
    wave_a_oe_out = mode.pwm | (pin_a.out_en & ~pin_a.cap_en);
    wave_b_oe_out = ~pwm_only & pin_b.out_en & ~pin_b.cap_en;
  end

  // Waveform pin inputs for capture, two stages before any use.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wsync1 <= 2'h0;
      wsync2 <= 2'h0;
      wdly <= 2'h0;
    end else begin
      wsync1 <= {wave_b_in, wave_a_in};
      wsync2 <= wsync1;
      wdly <= wsync2;
    end
  end

  // Read port.
  always_comb begin
    next_rdata = RD_ZERO;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_MODE: next_rdata = {{(CPT_DW-$bits(cpt_mode_s)){1'b0}}, mode};
        OFS_CTRL: next_rdata = {{(CPT_DW-$bits(cpt_ctrl_s)){1'b0}}, ctrl};
        OFS_IO: next_rdata = {1'b0, pin_b, 1'b0, pin_a};
        OFS_PHASE: next_rdata = {8'h00, cnten};
        OFS_STAT: next_rdata = {{(CPT_DW-$bits(cpt_evt_s)-1){1'b0}}, dir, stat};
        OFS_CNT: next_rdata = cnt;
        OFS_CMPA: next_rdata = cmp_a;
        OFS_CMPB: next_rdata = cmp_b;
        OFS_BUFA: next_rdata = buf_a;
        OFS_BUFB: next_rdata = buf_b;
        default: next_rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= RD_ZERO;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule

// ### sim/cpt_encoder_model.sv
// Purpose: Two-phase encoder driving the timer's clock and phase pins.
// Assumes: One quadrature state change for each cycle with step_in high.
// Notes: Push-pull outputs, so the pins always carry a driven level.
`timescale 1ns/1ps
module cpt_encoder_model (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Step requests.
  input wire logic step_in,
  input wire logic reverse_in,
  // Phase outputs.
  output logic phase_a_out,
  output logic phase_b_out
);
  logic [1:0] pos;
  logic [1:0] next_pos;
  always_comb begin
    next_pos = pos;
    if (step_in) begin
      next_pos = reverse_in ? pos - 2'h1 : pos + 2'h1;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pos <= 2'h0;
    end else begin
      pos <= next_pos;
    end
  end
  // Forward steps make A lead B, which the up conditions count.
  assign phase_a_out = pos[1] ^ pos[0];
  assign phase_b_out = pos[1];
endmodule

// ### sim/cpt_timer_chk.sv
// Purpose: Port-level checks for the compare, PWM and phase counting timer.
// Assumes: The mode register is shadowed from register writes.
// Notes: Sees only the top module's ports.
`timescale 1ns/1ps
module cpt_timer_chk
  import cpt_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Register port.
  input wire logic [CPT_AW-1:0] reg_addr_in,
  input wire logic [CPT_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [CPT_DW-1:0] reg_rdata_out,
  // Waveform pins and events.
  input wire logic wave_a_out,
  input wire logic wave_a_oe_out,
  input wire logic wave_b_oe_out,
  input wire cpt_evt_s irq_out
);
  cpt_mode_s mode_q;
  cpt_mode_s next_mode;
  always_comb begin
    next_mode = mode_q;
    if (reg_wr_in && reg_addr_in == OFS_MODE) begin
      next_mode = reg_wdata_in[2:0];
    end
  end
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q <= MODE_RST;
    end else begin
      mode_q <= next_mode;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == RD_ZERO)
    else $error("read data outside the answer cycle");
  AST_RD_UNMAPPED: assert property ($past(reg_rd_in) && $past(reg_addr_in) > OFS_BUFB
    |-> reg_rdata_out == RD_ZERO) else $error("unmapped read not zero");
  AST_MODE_READ: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFS_MODE
    |-> reg_rdata_out == {13'h0, $past(mode_q)}) else $error("mode read back wrong");
  AST_PWM_OE_A: assert property (mode_q.pwm |-> wave_a_oe_out)
    else $error("pin a not driven in pwm");
  AST_PWM_OE_B: assert property (mode_q.pwm && !mode_q.phase |-> !wave_b_oe_out)
    else $error("pin b driven in pwm");
  AST_OVF_RUN: assert property (irq_out.ovf |-> $past(mode_q.run))
    else $error("overflow while stopped");
  AST_UDF_PHASE: assert property (irq_out.udf |-> $past(mode_q.phase) && $past(mode_q.run))
    else $error("underflow outside running phase mode");
  AST_PWM_RISE: assert property ($past(mode_q.pwm) && $rose(wave_a_out) |-> irq_out.flag_a)
    else $error("pwm rise without match a");
  AST_PWM_FALL: assert property ($past(mode_q.pwm) && $fell(wave_a_out) |-> irq_out.flag_b)
    else $error("pwm fall without match b");
  COV_OVF: cover property (irq_out.ovf);
  COV_UDF: cover property (irq_out.udf);
  COV_PWM: cover property (mode_q.pwm && $rose(wave_a_out));
endmodule
bind cpt_timer cpt_timer_chk u_chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .wave_a_out(wave_a_out),
  .wave_a_oe_out(wave_a_oe_out), .wave_b_oe_out(wave_b_oe_out), .irq_out(irq_out));

// ### sim/tb_top.sv
// Purpose: Register-level tests of the compare, PWM and phase counting timer.
// Assumes: Waveform pin B has a pull-up when the timer does not drive it; pin A has an outside driver.
// Notes: Event pulses and pin edges are counted in the background.
`timescale 1ns/1ps
module tb_top;
  import cpt_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [CPT_AW-1:0] reg_addr_in = 4'h0;
  logic [CPT_DW-1:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic enc_step = 1'b0;
  logic enc_rev = 1'b0;
  // Outside driver on pin A; it rests high, like the pull-up.
  logic ext_a = 1'b1;
  logic [CPT_DW-1:0] reg_rdata_out;
  logic pin_a, pin_b, wave_a_out, wave_a_oe_out, wave_b_out, wave_b_oe_out, wave_prev;
  wire logic wave_a_in = wave_a_oe_out ? wave_a_out : ext_a;
  wire logic wave_b_in = wave_b_oe_out ? wave_b_out : 1'b1;
  cpt_evt_s irq_out;
  int errors = 0;
  int comparisons = 0;
  int n_fa, n_ovf, n_udf, n_tog, n_rise, n_fall;
  logic [2:0] srcs[5] = '{SRC_DIV1, SRC_DIV2, SRC_DIV4, SRC_DIV8, SRC_DIV32};
  int divs[5] = '{1, 2, 4, 8, 32};
  cpt_encoder_model ENC (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .step_in(enc_step),
    .reverse_in(enc_rev), .phase_a_out(pin_a), .phase_b_out(pin_b));
  cpt_timer DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .clk_pin_a_in(pin_a), .clk_pin_b_in(pin_b),
    .wave_a_in(wave_a_in), .wave_a_out(wave_a_out), .wave_a_oe_out(wave_a_oe_out),
    .wave_b_in(wave_b_in), .wave_b_out(wave_b_out), .wave_b_oe_out(wave_b_oe_out),
    .irq_out(irq_out));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    n_fa += int'(irq_out.flag_a === 1'b1);
    n_ovf += int'(irq_out.ovf === 1'b1);
    n_udf += int'(irq_out.udf === 1'b1);
    n_tog += int'(wave_a_out !== wave_prev);
    n_rise += int'(wave_a_out === 1'b1 && wave_prev === 1'b0);
    n_fall += int'(wave_a_out === 1'b0 && wave_prev === 1'b1);
    wave_prev = wave_a_out;
  end
  task automatic clr_counts();
    {n_fa, n_ovf, n_udf, n_tog, n_rise, n_fall} = '0;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [CPT_AW-1:0] a, input logic [CPT_DW-1:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rchk(input logic [CPT_AW-1:0] a, input logic [CPT_DW-1:0] exp, input string n);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(n, exp, reg_rdata_out);
  endtask
  // Steps are spaced well beyond the pin synchroniser latency.
  task automatic enc(input int n, input logic rev);
    enc_rev <= rev;
    repeat (n) begin
      @(posedge mclk_in);
      enc_step <= 1'b1;
      @(posedge mclk_in);
      enc_step <= 1'b0;
      repeat (6) @(posedge mclk_in);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rchk(OFS_CMPA, CMP_RST, "compare a");
    rchk(4'hc, RD_ZERO, "unmapped");
    wr(OFS_CNT, 16'h1234);
    repeat (20) @(posedge mclk_in);
    rchk(OFS_CNT, 16'h1234, "held count");
    // A 64-cycle run window holds an exact number of prescaler ticks.
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CNT, 16'h0000);
      wr(OFS_CTRL, {13'h0, srcs[i]});
      wr(OFS_MODE, 16'h0001);
      repeat (62) @(posedge mclk_in);
      wr(OFS_MODE, 16'h0000);
      rchk(OFS_CNT, 16'(64 / divs[i]), "prescaled count");
    end
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CNT, 16'h0000);
      wr(OFS_CTRL, (i == 0) ? 16'h0005 : 16'h000f);
      wr(OFS_MODE, 16'h0001);
      enc(8, 1'b0);
      wr(OFS_MODE, 16'h0000);
      rchk(OFS_CNT, 16'h0002, "pin clock count");
    end
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CNT, 16'hfffe);
    wr(OFS_STAT, 16'h000f);
    clr_counts();
    wr(OFS_MODE, 16'h0001);
    wr(OFS_MODE, 16'h0000);
    rchk(OFS_CNT, 16'h0000, "wrapped count");
    chk("overflow pulses", 16'h0001, 16'(n_ovf));
    rchk(OFS_STAT, 16'h0017, "status");
    wr(OFS_CMPA, 16'h0002);
    wr(OFS_CTRL, 16'h0020);
    wr(OFS_IO, 16'h0006);
    wr(OFS_CNT, 16'h0000);
    clr_counts();
    wr(OFS_MODE, 16'h0001);
    repeat (30) @(posedge mclk_in);
    wr(OFS_MODE, 16'h0000);
    repeat (3) @(posedge mclk_in);
    rchk(OFS_CNT, 16'h0002, "cleared count");
    chk("match a pulses", 16'd10, 16'(n_fa));
    chk("pin a toggles", 16'd10, 16'(n_tog));
    chk("pin b enable", 16'h0000, 16'(wave_b_oe_out));
    wr(OFS_CMPA, 16'h0004);
    wr(OFS_CMPB, 16'h000a);
    wr(OFS_CTRL, 16'h0040);
    wr(OFS_CNT, 16'h0000);
    wr(OFS_MODE, 16'h0003);
    clr_counts();
    repeat (40) @(posedge mclk_in);
    chk("pwm pin enables", 16'h0001, {14'h0, wave_b_oe_out, wave_a_oe_out});
    wr(OFS_MODE, 16'h0000);
    repeat (3) @(posedge mclk_in);
    chk("pwm rises", 16'd4, 16'(n_rise));
    chk("pwm falls", 16'd3, 16'(n_fall));
    wr(OFS_CNT, 16'h0000);
    wr(OFS_PHASE, 16'h000f);
    wr(OFS_MODE, 16'h0005);
    rchk(OFS_MODE, 16'h0005, "mode");
    enc(8, 1'b0);
    rchk(OFS_CNT, 16'h0008, "phase up count");
    wr(OFS_PHASE, 16'h00f0);
    clr_counts();
    enc(12, 1'b1);
    rchk(OFS_CNT, 16'hfffc, "phase down count");
    chk("underflow pulses", 16'h0001, 16'(n_udf));
    // Pin B alone drives: a match sets it high and reloads compare B from its buffer.
    wr(OFS_MODE, 16'h0000);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CNT, 16'h0000);
    wr(OFS_CMPB, 16'h0003);
    wr(OFS_BUFB, 16'h0007);
    wr(OFS_IO, 16'h4500);
    wr(OFS_MODE, 16'h0001);
    repeat (10) @(posedge mclk_in);
    wr(OFS_MODE, 16'h0000);
    chk("wave b level", 16'h0001, 16'(wave_b_out));
    chk("pin enables", 16'h0002, {14'h0, wave_b_oe_out, wave_a_oe_out});
    rchk(OFS_CMPB, 16'h0007, "reloaded compare b");
    // The counter now holds 12; a falling edge on pin A in phase mode captures it.
    wr(OFS_MODE, 16'h0004);
    wr(OFS_IO, 16'h0018);
    clr_counts();
    ext_a <= 1'b0;
    repeat (5) @(posedge mclk_in);
    rchk(OFS_CMPA, 16'h000c, "captured count");
    chk("capture pulses", 16'h0001, 16'(n_fa));
    complete_run();
  end
endmodule
